//--- src/fssr_pkg.sv
// Constants and types of the frame-synchronised shadow register bank
package fssr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int NREG = 16;
    // Register indices
    localparam logic [7:0] A_ROW_WIDTH = 8'h03;
    localparam logic [7:0] A_INTEG = 8'h09;
    localparam logic [7:0] A_CTRL = 8'h0D;
    localparam logic [7:0] A_DARK_CFG = 8'h22;
    localparam logic [7:0] A_GAIN_G1 = 8'h2B;
    localparam logic [7:0] A_GAIN_GLOB = 8'h2F;
    localparam logic [7:0] A_STATUS = 8'h40;
    // Control bits
    localparam int CTRL_INHIBIT = 15;
    localparam int CTRL_SHOW_BAD = 8;
    // Field masks (undefined bits read zero)
    localparam logic [15:0] M_ROW_WIDTH = 16'h01FF;
    localparam logic [15:0] M_INTEG = 16'h7FFF;
    localparam logic [15:0] M_CTRL = 16'h8100;
    localparam logic [15:0] M_DARK = 16'h00FF;
    localparam logic [15:0] M_GAIN = 16'h0FFF;
    // Reset values
    localparam logic [15:0] R_ROW_WIDTH = 16'h01E0;
    localparam logic [15:0] R_INTEG = 16'h01F4;
    localparam logic [15:0] R_GAIN = 16'h0020;
    localparam logic [15:0] R_GAIN_BLUE = 16'h0040;
    localparam logic [15:0] R_ZERO = 16'h0000;
    // Rows from frame start to frame-valid rise
    localparam int DARK_ROWS = 6;
    typedef struct packed {
        logic [15:0] row_width;
        logic [15:0] integ;
        logic [4:0][15:0] gain;
    } fssr_live_t;
    typedef enum logic [1:0] {
        FSSR_IDLE = 2'b00,
        FSSR_DARK = 2'b01,
        FSSR_ACTIVE = 2'b11
    } fssr_state_t;
endpackage

//--- src/fssr_top.sv
// Frame-synchronised shadow register bank with bad-frame masking
//
// What this block does
// - Undefined register bits are read-only and always read back as zero.
// - Software reaches pending copies only; live copies steer the sensor.
// - Pending row width, integration and undeferred gains move to live copies together at frame start.
// - Frame start is first dark row, six rows before frame-valid rises.
// - Showing dark rows in the image does not move frame start.
// - Transfer-inhibit bit blocks pending-to-live copies; host sets it for batches.
// - Frame is bad when integration times differ or offsets changed mid frame; here only a row width write marks a frame bad.
// - Bad frames keep row-valid and frame-valid low, stretching blanking.
// - Show-bad-frames bit lets masked bad frames out unmasked.
// - Non-disturbing writes never make a bad frame; disturbing ones may.
// - New row width applies at next frame start; that frame is bad.
// - Integration time written during frame N first shows in frame N+2.
// - Integration waits pending, goes live at N+1 start, applies per row.
// - Back-to-back integration writes each govern one frame, latency fixed.
// - Color and global gain changes normally apply at next frame start.
// - Gain changed with integration time is delayed one more frame.
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module fssr_top
    import fssr_pkg::*;
#(
    parameter int ROW_CYCLES = 16
) (
    input wire logic I_CLK_SYS,
    input wire logic I_SRST,
    input wire logic [fssr_pkg::ADDR_W-1:0] I_ADDR,
    input wire logic [fssr_pkg::DATA_W-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic I_FRAME_GO,
    input wire logic [7:0] I_ROWS,
    output logic [fssr_pkg::DATA_W-1:0] O_RDATA,
    output fssr_pkg::fssr_live_t O_LIVE,
    output logic O_INTEG_APPLY,
    output logic O_FRAME_START,
    output logic O_FRAME_VALID,
    output logic O_LINE_VALID
);
    import fssr_pkg::*;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic go_s1, go_s2, go_s3;
    logic [7:0] rows_s1, rows_s2;
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            go_s1 <= 1'b0;
            go_s2 <= 1'b0;
            go_s3 <= 1'b0;
            rows_s1 <= 8'h00;
            rows_s2 <= 8'h00;
        end else begin
            go_s1 <= I_FRAME_GO;
            go_s2 <= go_s1;
            go_s3 <= go_s2;
            rows_s1 <= I_ROWS;
            rows_s2 <= rows_s1;
        end
    end
    wire go_rise = go_s2 & ~go_s3;

    // ----------------------------------------------------------------
    // Frame timing
    // ----------------------------------------------------------------
    fssr_state_t state, next_state;
    logic [15:0] cyc, next_cyc;
    logic [15:0] row, next_row;
    logic fstart, next_fstart;
    logic row_end;
    logic [15:0] active_rows;
    fssr_live_t live, next_live;

    always_comb begin
        active_rows = live.row_width & M_ROW_WIDTH;
        row_end = (cyc == 16'(ROW_CYCLES - 1));
        next_state = state;
        next_cyc = row_end ? 16'h0000 : cyc + 16'h0001;
        next_row = row;
        next_fstart = 1'b0;
        unique case (state)
            FSSR_IDLE: begin
                next_cyc = 16'h0000;
                if (go_rise) begin
                    // First dark row read; dark-row display never moves it
                    next_state = FSSR_DARK;
                    next_row = 16'h0000;
                    next_fstart = 1'b1;
                end
            end
            FSSR_DARK: begin
                if (row_end) begin
                    next_row = row + 16'h0001;
                    if (row == 16'(DARK_ROWS - 1)) begin
                        next_state = FSSR_ACTIVE;
                        next_row = 16'h0000;
                    end
                end
            end
            FSSR_ACTIVE: begin
                if (row_end) begin
                    next_row = row + 16'h0001;
                    if (row == active_rows - 16'h0001) begin
                        next_state = FSSR_IDLE;
                    end
                end
            end
            default: next_state = FSSR_IDLE;
        endcase
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            state <= FSSR_IDLE;
            cyc <= 16'h0000;
            row <= 16'h0000;
            fstart <= 1'b0;
        end else begin
            state <= next_state;
            cyc <= next_cyc;
            row <= next_row;
            fstart <= next_fstart;
        end
    end

    // ----------------------------------------------------------------
    // Pending and live registers
    // ----------------------------------------------------------------
    logic [15:0] p_row_width, p_integ, p_ctrl, p_dark;
    logic [4:0][15:0] p_gain;
    logic [4:0][15:0] gain_hold, next_gain_hold;
    logic gain_defer, next_gain_defer;
    logic integ_dirty, next_integ_dirty;
    logic gain_dirty, next_gain_dirty;
    logic bad_next, next_bad_next;
    logic bad_cur, next_bad_cur;
    logic [15:0] n_row_width, n_integ, n_ctrl, n_dark;
    logic [4:0][15:0] n_gain;

    function automatic logic is_gain(input logic [7:0] a);
        return (a >= A_GAIN_G1) && (a <= A_GAIN_GLOB);
    endfunction

    wire inhibit = p_ctrl[CTRL_INHIBIT];
    wire show_bad = p_ctrl[CTRL_SHOW_BAD];
    wire xfer = fstart && !inhibit;

    always_comb begin
        n_row_width = p_row_width;
        n_integ = p_integ;
        n_ctrl = p_ctrl;
        n_dark = p_dark;
        n_gain = p_gain;
        next_live = live;
        next_gain_hold = gain_hold;
        next_gain_defer = gain_defer;
        next_integ_dirty = integ_dirty;
        next_gain_dirty = gain_dirty;
        next_bad_next = bad_next;
        next_bad_cur = bad_cur;
        if (xfer) begin
            // Row width, integration and undeferred gains move at once
            next_live.row_width = p_row_width;
            next_live.integ = p_integ;
            if (gain_defer) begin
                next_live.gain = gain_hold;
            end
            next_gain_defer = 1'b0;
            if (gain_dirty && integ_dirty) begin
                // Gain follows new exposure to its first output frame
                next_gain_hold = p_gain;
                next_gain_defer = 1'b1;
            end else begin
                next_live.gain = p_gain;
            end
            next_integ_dirty = 1'b0;
            next_gain_dirty = 1'b0;
            // Frame read now was integrated under old settings
            next_bad_cur = bad_next;
            next_bad_next = 1'b0;
        end else if (fstart) begin
            next_bad_cur = 1'b0;
        end
        // Set wins over the transfer clear
        if (I_WR) begin
            unique case (I_ADDR)
                A_ROW_WIDTH: begin
                    n_row_width = I_WDATA & M_ROW_WIDTH;
                    next_bad_next = 1'b1;
                end
                A_INTEG: begin
                    n_integ = I_WDATA & M_INTEG;
                    next_integ_dirty = 1'b1;
                end
                A_CTRL: n_ctrl = I_WDATA & M_CTRL;
                A_DARK_CFG: n_dark = I_WDATA & M_DARK;
                default: begin
                    if (is_gain(I_ADDR)) begin
                        n_gain[3'(I_ADDR - A_GAIN_G1)] = I_WDATA & M_GAIN;
                        next_gain_dirty = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            p_row_width <= R_ROW_WIDTH;
            p_integ <= R_INTEG;
            p_ctrl <= R_ZERO;
            p_dark <= R_ZERO;
            p_gain <= {R_GAIN, R_GAIN, R_GAIN, R_GAIN_BLUE, R_GAIN};
            live <= {R_ROW_WIDTH, R_INTEG, R_GAIN, R_GAIN, R_GAIN, R_GAIN_BLUE, R_GAIN};
            gain_hold <= {R_GAIN, R_GAIN, R_GAIN, R_GAIN_BLUE, R_GAIN};
            gain_defer <= 1'b0;
            integ_dirty <= 1'b0;
            gain_dirty <= 1'b0;
            bad_next <= 1'b0;
            bad_cur <= 1'b0;
        end else begin
            p_row_width <= n_row_width;
            p_integ <= n_integ;
            p_ctrl <= n_ctrl;
            p_dark <= n_dark;
            p_gain <= n_gain;
            live <= next_live;
            gain_hold <= next_gain_hold;
            gain_defer <= next_gain_defer;
            integ_dirty <= next_integ_dirty;
            gain_dirty <= next_gain_dirty;
            bad_next <= next_bad_next;
            bad_cur <= next_bad_cur;
        end
    end

    // ----------------------------------------------------------------
    // Read port and outputs
    // ----------------------------------------------------------------
    logic [15:0] next_rdata;
    logic next_fv, next_lv, next_apply;
    always_comb begin
        next_rdata = R_ZERO;
        if (I_RD) begin
            unique case (I_ADDR)
                A_ROW_WIDTH: next_rdata = p_row_width;
                A_INTEG: next_rdata = p_integ;
                A_CTRL: next_rdata = p_ctrl;
                A_DARK_CFG: next_rdata = p_dark;
                A_STATUS: next_rdata = {13'h0000, bad_cur, gain_defer, inhibit};
                default: begin
                    if (is_gain(I_ADDR)) begin
                        next_rdata = p_gain[3'(I_ADDR - A_GAIN_G1)];
                    end
                end
            endcase
        end
        // Masked bad frame adds one frame of blanking
        next_fv = (state == FSSR_ACTIVE) && (!bad_cur || show_bad);
        next_lv = next_fv && (cyc < 16'(ROW_CYCLES / 2));
        // New exposure starts on each row right after its readout
        next_apply = (state == FSSR_ACTIVE) && row_end;
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            O_RDATA <= R_ZERO;
            O_LIVE <= {R_ROW_WIDTH, R_INTEG, R_GAIN, R_GAIN, R_GAIN, R_GAIN_BLUE, R_GAIN};
            O_INTEG_APPLY <= 1'b0;
            O_FRAME_START <= 1'b0;
            O_FRAME_VALID <= 1'b0;
            O_LINE_VALID <= 1'b0;
        end else begin
            O_RDATA <= next_rdata;
            O_LIVE <= next_live;
            O_INTEG_APPLY <= next_apply;
            O_FRAME_START <= fstart;
            O_FRAME_VALID <= next_fv;
            O_LINE_VALID <= next_lv;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    inhibit_hold_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
        (fstart && inhibit) |=> (live == $past(live)))
        else $error("live copy changed while inhibited");
    xfer_copy_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
        xfer |=> (live.integ == $past(p_integ) && live.row_width == $past(p_row_width)))
        else $error("pending not copied at frame start");
    quiet_live_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
        !fstart |=> (live == $past(live)))
        else $error("live copy changed outside frame start");
    fv_delay_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
        (state == FSSR_DARK) |=> !O_FRAME_VALID)
        else $error("frame valid during dark rows");
    mask_bad_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
        (bad_cur && !show_bad && $stable(bad_cur) && $stable(show_bad)) |=> !O_FRAME_VALID)
        else $error("bad frame not masked");
    width_bad_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
        (I_WR && I_ADDR == A_ROW_WIDTH) |=> bad_next)
        else $error("row width write not flagged");
    gain_defer_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
        (xfer && integ_dirty && gain_dirty) |=> (gain_defer &&
            live.gain == ($past(gain_defer) ? $past(gain_hold) : $past(live.gain))))
        else $error("gain not deferred with exposure");
    gain_now_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
        (xfer && gain_dirty && !integ_dirty && !gain_defer) |=> (live.gain == $past(p_gain)))
        else $error("gain not applied at frame start");
    rsv_zero_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
        (I_RD && I_ADDR == A_CTRL) |=> ((O_RDATA & ~M_CTRL) == R_ZERO))
        else $error("undefined bits read nonzero");
endmodule // fssr_top

//--- verif/fssr_host.sv
// Host model driving the register port of the shadow register bank
`timescale 1ns/100ps
module fssr_host (
    input wire logic i_clk,
    input wire logic [fssr_pkg::DATA_W-1:0] i_rdata,
    output logic [fssr_pkg::ADDR_W-1:0] o_addr,
    output logic [fssr_pkg::DATA_W-1:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    import fssr_pkg::*;
    initial begin
        o_addr = 8'h00;
        o_wdata = 16'h0000;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // Idle bus shows inverted last value so stale data never looks valid
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1 d = i_rdata;
    endtask
endmodule // fssr_host

//--- verif/fssr_top_bench.sv
// Self-checking testbench of the shadow register bank
`timescale 1ns/100ps
module fssr_top_bench;
    import fssr_pkg::*;
    localparam int RC = 4;
    logic I_CLK_SYS = 1'b0;
    logic I_SRST = 1'b1;
    logic I_FRAME_GO = 1'b0;
    logic [7:0] I_ROWS = 8'h00;
    logic [ADDR_W-1:0] I_ADDR;
    logic [DATA_W-1:0] I_WDATA, O_RDATA;
    logic I_WR, I_RD, O_INTEG_APPLY, O_FRAME_START, O_FRAME_VALID, O_LINE_VALID;
    fssr_live_t O_LIVE;
    int miscompares = 0;
    int tests_run = 0;
    int pend[int];
    int lrow = 'h1E0, linteg = 'h1F4;
    int lg[5] = '{'h20, 'h40, 'h20, 'h20, 'h20};
    bit dr, di, dg, bad, dh;
    int hg[5];
    always #25 I_CLK_SYS = ~I_CLK_SYS;
    fssr_host host (.i_clk(I_CLK_SYS), .i_rdata(O_RDATA), .o_addr(I_ADDR),
        .o_wdata(I_WDATA), .o_wr(I_WR), .o_rd(I_RD));
    fssr_top #(.ROW_CYCLES(RC)) dut (.I_CLK_SYS(I_CLK_SYS), .I_SRST(I_SRST),
        .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
        .I_FRAME_GO(I_FRAME_GO), .I_ROWS(I_ROWS), .O_RDATA(O_RDATA), .O_LIVE(O_LIVE),
        .O_INTEG_APPLY(O_INTEG_APPLY), .O_FRAME_START(O_FRAME_START),
        .O_FRAME_VALID(O_FRAME_VALID), .O_LINE_VALID(O_LINE_VALID));
    task automatic stop_test();
        if (miscompares == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic mwr(input int a, input int d);
        case (a)
            'h03: begin pend[a] = d & 'h01FF; dr = 1; end
            'h09: begin pend[a] = d & 'h7FFF; di = 1; end
            'h0D: pend[a] = d & 'h8100;
            'h22: pend[a] = d & 'h00FF;
            'h2B, 'h2C, 'h2D, 'h2E, 'h2F: begin pend[a] = d & 'h0FFF; dg = 1; end
            default: ;
        endcase
        host.wr(a[7:0], d[15:0]);
    endtask
    task automatic mrd(input int a);
        logic [15:0] d;
        host.rd(a[7:0], d);
        check(d, pend.exists(a) ? pend[a][15:0] : 16'h0000);
    endtask
    task automatic live_chk();
        check(O_LIVE.row_width, lrow[15:0]);
        check(O_LIVE.integ, linteg[15:0]);
        for (int g = 0; g < 5; g++) check(O_LIVE.gain[g], lg[g][15:0]);
    endtask
    task automatic frame();
        int n;
        int nlv = 0;
        int nap = 0;
        logic [15:0] st;
        @(posedge I_CLK_SYS) I_FRAME_GO <= 1'b1;
        n = 0;
        do begin @(posedge I_CLK_SYS); #1 n++; end while (O_FRAME_START !== 1'b1 && n < 20);
        if (n >= 20) begin miscompares++; stop_test(); end
        I_FRAME_GO <= 1'b0;
        // Transfer model: integ and gain together holds gain back one frame
        bad = 0;
        if (pend['h0D][15] == 0) begin
            bad = dr;
            lrow = pend['h03];
            linteg = pend['h09];
            if (dh) lg = hg;
            dh = di && dg;
            for (int g = 0; g < 5; g++) begin
                if (dh) hg[g] = pend['h2B + g];
                else lg[g] = pend['h2B + g];
            end
            dr = 0;
            di = 0;
            dg = 0;
        end
        @(posedge I_CLK_SYS) #1 live_chk();
        n = 1;
        while (O_FRAME_VALID !== 1'b1 && n < 6 * RC + 3) begin
            @(posedge I_CLK_SYS);
            #1 n++;
            nlv += int'(O_LINE_VALID);
            nap += int'(O_INTEG_APPLY);
        end
        if (!bad || pend['h0D][8]) begin
            check(n >= 6 * RC - 1 && n <= 6 * RC + 1, 1'b1);
        end else begin
            check(O_FRAME_VALID, 1'b0);
        end
        repeat (lrow * RC + 8) begin
            @(posedge I_CLK_SYS);
            #1 nlv += int'(O_LINE_VALID);
            nap += int'(O_INTEG_APPLY);
        end
        check(16'(nap), 16'(lrow));
        check(16'(nlv), (!bad || pend['h0D][8]) ? 16'(lrow * RC / 2) : 16'h0000);
        host.rd(A_STATUS, st);
        check(st, {13'h0000, bad, dh, pend['h0D][15]});
    endtask
    initial begin
        int ad[10] = '{'h03, 'h09, 'h0D, 'h22, 'h2B, 'h2C, 'h2D, 'h2E, 'h2F, 'h41};
        void'($urandom(32'h6a391095));
        pend = '{'h03: 'h1E0, 'h09: 'h1F4, 'h0D: 0, 'h22: 0, 'h2B: 'h20, 'h2C: 'h40,
            'h2D: 'h20, 'h2E: 'h20, 'h2F: 'h20};
        repeat (20) @(posedge I_CLK_SYS);
        I_SRST <= 1'b0;
        I_ROWS <= 8'($urandom);
        #1 live_chk();
        foreach (ad[i]) mrd(ad[i]);
        mwr('h03, 'hFE02);
        mwr('h41, 'h1234);
        mrd('h03);
        mrd('h41);
        live_chk();
        frame();
        mwr('h2B + $urandom_range(4), $urandom);
        frame();
        mwr('h09, $urandom);
        mwr('h2F, $urandom);
        frame();
        frame();
        mwr('h0D, 'h8000);
        mwr('h09, $urandom);
        mwr('h2C, $urandom);
        frame();
        mwr('h0D, 'h0000);
        frame();
        frame();
        mwr('h22, 'h00FF);
        mwr('h0D, 'h0100);
        mwr('h03, 'h0003);
        frame();
        mwr('h0D, 'h0000);
        repeat (2) begin
            mwr('h09, $urandom);
            frame();
        end
        foreach (ad[i]) mrd(ad[i]);
        stop_test();
    end
endmodule // fssr_top_bench
